// *** rtl/wrg_defs.svh ***
`ifndef WRG_DEFS_SVH
`define WRG_DEFS_SVH

// ****************************************************************
// Set 1 control register offsets
// ****************************************************************
`define WRG_OFS_PTR_LOW 8'hD6
`define WRG_OFS_PTR_HIGH 8'hD7
`define WRG_OFS_PAGE_PTR 8'hDF

// ****************************************************************
// Reset values
// ****************************************************************
`define WRG_RST_PTR_LOW 8'hC0
`define WRG_RST_PTR_HIGH 8'hC8
`define WRG_RST_PAGE_PTR 8'h00

// ****************************************************************
// Address map boundaries and field layout
// ****************************************************************
`define WRG_PRIME_TOP 8'hBF
`define WRG_SLICE_STEP 8'h08
`define WRG_WORK_NIBBLE 4'hC
`define WRG_SLICE_MSB 7
`define WRG_SLICE_LSB 3
`define WRG_PTR_SEL_BIT 3
`define WRG_PAGE_SRC_MSB 3
`define WRG_PAGE_SRC_LSB 0
`define WRG_PAGE_DST_MSB 7
`define WRG_PAGE_DST_LSB 4

`endif

// *** rtl/wrg_pkg.sv ***
package wrg_pkg;

  // ****************************************************************
  // Operand addressing forms seen by the resolver
  // ****************************************************************
  typedef enum logic [1:0] {
    WRG_MODE_WORK4 = 2'h0,
    WRG_MODE_REG8 = 2'h1,
    WRG_MODE_INDIR = 2'h2
  } wrg_mode_type;

  // Physical space an operand lands in
  typedef enum logic [1:0] {
    WRG_SPACE_PRIME = 2'h0,
    WRG_SPACE_SET1 = 2'h1,
    WRG_SPACE_SET2 = 2'h2
  } wrg_space_type;

  // Pointer-setting instructions from the decoder
  typedef enum logic [1:0] {
    WRG_CMD_NONE = 2'h0,
    WRG_CMD_BOTH = 2'h1,
    WRG_CMD_LOW = 2'h2,
    WRG_CMD_HIGH = 2'h3
  } wrg_cmd_type;

  // Upper five pointer bits joined with three operand bits
  function automatic logic [7:0] wrg_join(input logic [7:0] ptr, input logic [2:0] reg_sel);
    wrg_join = {ptr[7:3], reg_sel};
  endfunction

endpackage

// *** rtl/wrg_slice_ptr.sv ***
`timescale 1ns/1ps
`include "wrg_defs.svh"

module wrg_slice_ptr #(
  parameter logic [7:0] RESET_VAL = `WRG_RST_PTR_LOW
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic arst_n_i,
  // Load port
  input wire logic ld_en_i,
  input wire logic [7:0] ld_val_i,
  // Stored pointer
  output logic [7:0] ptr_o
);

  // ****************************************************************
  // Pointer storage, all eight bits kept for read back
  // ****************************************************************
  logic [7:0] ptr_ff;

  // Load only on its own enable, the sibling pointer is untouched
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      ptr_ff <= RESET_VAL;
    end else if (ld_en_i) begin
      ptr_ff <= ld_val_i; // see [RULE_21]
    end
  end

  assign ptr_o = ptr_ff;

endmodule

// *** rtl/wrg_operand_resolve.sv ***
`timescale 1ns/1ps
`include "wrg_defs.svh"

module wrg_operand_resolve (
  // Operand from the decoder
  input wire wrg_pkg::wrg_mode_type mode_i,
  input wire logic [7:0] field_i,
  input wire logic pair_i,
  // Current pointers and page for this operand role
  input wire logic [7:0] ptr_low_i,
  input wire logic [7:0] ptr_high_i,
  input wire logic [3:0] page_i,
  // Resolved location
  output logic [7:0] addr_o,
  output wrg_pkg::wrg_space_type space_o,
  output logic [3:0] page_o,
  output logic wref_o,
  output logic odd_o
);

  // ****************************************************************
  // Working-register detection and address formation
  // ****************************************************************
  logic is_work;
  logic [7:0] sel_ptr;

  // Short form always, long form only with the 1100B prefix
  assign is_work = (mode_i == wrg_pkg::WRG_MODE_WORK4) ||
                   ((mode_i == wrg_pkg::WRG_MODE_REG8) &&
                    (field_i[7:4] == `WRG_WORK_NIBBLE)); // see [RULE_17]
  // Same bit serves both forms since the low nibble is shared
  assign sel_ptr = field_i[`WRG_PTR_SEL_BIT] ? ptr_high_i : ptr_low_i; // see [RULE_15] see [RULE_18]
  assign addr_o = is_work ? wrg_pkg::wrg_join(sel_ptr, field_i[2:0]) : field_i; // see [RULE_16] see [RULE_03]
  assign wref_o = is_work;
  // Pairs live on even addresses, an odd one is flagged
  assign odd_o = pair_i & addr_o[0]; // see [RULE_12]

  // Space selection, prime first since every mode reaches it
  always_comb begin
    if (addr_o <= `WRG_PRIME_TOP) begin
      space_o = wrg_pkg::WRG_SPACE_PRIME; // see [RULE_01]
    end else if (!is_work && (mode_i == wrg_pkg::WRG_MODE_INDIR)) begin
      space_o = wrg_pkg::WRG_SPACE_SET2;
    end else begin
      space_o = wrg_pkg::WRG_SPACE_SET1; // see [RULE_09] see [RULE_11] see [RULE_13]
    end
  end

  // Set 1 and common area ignore the page
  assign page_o = (space_o == wrg_pkg::WRG_SPACE_SET1) ? 4'h0 : page_i; // see [RULE_13]

endmodule

// *** rtl/wrg_addr_gen.sv ***
// How it works
// [RULE_01] Prime area 00H-BFH reachable by every mode
// [RULE_02] Page 0 prime at reset, others via page pointer
// [RULE_03] Register file seen as 32 eight-byte slices
// [RULE_04] Two pointers pick two slices, one block
// [RULE_05] Slice identified by upper five address bits
// [RULE_06] Pointers at D6H/D7H, reset to common area
// [RULE_07] Set-both loads V and V+8; singles alone
// [RULE_08] Register write alters only the named pointer
// [RULE_09] Working operands never land in set 2
// [RULE_10] Pointers independent, any slice order allowed
// [RULE_11] Direct register mode reaches all but set 2
// [RULE_12] Pairs even-addressed, even byte is MSB
// [RULE_13] Common area usable on any page
// [RULE_14] Software uses working form for common area
// [RULE_15] 4-bit operand top bit picks the pointer
// [RULE_16] Address is pointer[7:3] joined with operand[2:0]
// [RULE_17] 8-bit operand with 1100B prefix is working
// [RULE_18] Bit 3 of long form picks the pointer
// [RULE_19] Page pointer nibbles clear to zero on reset
// [RULE_20] Pointer reset values exactly C0H and C8H
// [RULE_21] Low three pointer bits stored and read back
`timescale 1ns/1ps
`include "wrg_defs.svh"

module wrg_addr_gen (
  // Clock and reset
  input wire logic CLK_I,
  input wire logic ARST_N_I,
  // Pointer-setting instructions
  input wire wrg_pkg::wrg_cmd_type PTR_CMD_I,
  input wire logic [7:0] PTR_CMD_VAL_I,
  // Register-file write from the datapath
  input wire logic REG_WR_EN_I,
  input wire logic [7:0] REG_WR_ADDR_I,
  input wire logic REG_WR_SET2_I,
  input wire logic [7:0] REG_WR_DATA_I,
  // Register-file read of the control registers
  input wire logic REG_RD_EN_I,
  input wire logic [7:0] REG_RD_ADDR_I,
  input wire logic REG_RD_SET2_I,
  // Operand requests
  input wire logic OPND_VALID_I,
  input wire wrg_pkg::wrg_mode_type SRC_MODE_I,
  input wire logic [7:0] SRC_FIELD_I,
  input wire logic SRC_PAIR_I,
  input wire wrg_pkg::wrg_mode_type DST_MODE_I,
  input wire logic [7:0] DST_FIELD_I,
  input wire logic DST_PAIR_I,
  // Resolved source operand
  output logic OPND_VALID_O,
  output logic [7:0] SRC_ADDR_O,
  output wrg_pkg::wrg_space_type SRC_SPACE_O,
  output logic [3:0] SRC_PAGE_O,
  output logic SRC_WREF_O,
  output logic SRC_ODD_O,
  // Resolved destination operand
  output logic [7:0] DST_ADDR_O,
  output wrg_pkg::wrg_space_type DST_SPACE_O,
  output logic [3:0] DST_PAGE_O,
  output logic DST_WREF_O,
  output logic DST_ODD_O,
  // Read answer
  output logic REG_RD_HIT_O,
  output logic [7:0] REG_RD_DATA_O,
  // Live control state
  output logic [7:0] SLICE_PTR_LOW_O,
  output logic [7:0] SLICE_PTR_HIGH_O,
  output logic [7:0] PAGE_PTR_O
);

  // ****************************************************************
  // Register decode
  // ****************************************************************
  logic wr_set1;
  logic wr_low;
  logic wr_high;
  logic wr_page;
  logic rd_set1;

  // Only register-mode writes reach set 1; set 2 writes share offsets
  assign wr_set1 = REG_WR_EN_I & ~REG_WR_SET2_I;
  assign wr_low = wr_set1 & (REG_WR_ADDR_I == `WRG_OFS_PTR_LOW); // see [RULE_06]
  assign wr_high = wr_set1 & (REG_WR_ADDR_I == `WRG_OFS_PTR_HIGH); // see [RULE_06]
  assign wr_page = wr_set1 & (REG_WR_ADDR_I == `WRG_OFS_PAGE_PTR);
  assign rd_set1 = REG_RD_EN_I & ~REG_RD_SET2_I;

  // ****************************************************************
  // Slice pointer load selection
  // ****************************************************************
  logic ld_low;
  logic ld_high;
  logic [7:0] ld_low_val;
  logic [7:0] ld_high_val;
  logic [7:0] ptr_low;
  logic [7:0] ptr_high;

  // Instruction load wins over a register write in the same cycle
  always_comb begin
    ld_low = wr_low; // see [RULE_08]
    ld_high = wr_high; // see [RULE_08]
    ld_low_val = REG_WR_DATA_I;
    ld_high_val = REG_WR_DATA_I;
    unique case (PTR_CMD_I)
      wrg_pkg::WRG_CMD_BOTH: begin
        ld_low = 1'b1;
        ld_high = 1'b1;
        ld_low_val = PTR_CMD_VAL_I; // see [RULE_07]
        ld_high_val = PTR_CMD_VAL_I + `WRG_SLICE_STEP; // see [RULE_07]
      end
      wrg_pkg::WRG_CMD_LOW: begin
        ld_low = 1'b1;
        ld_low_val = PTR_CMD_VAL_I; // see [RULE_07]
      end
      wrg_pkg::WRG_CMD_HIGH: begin
        ld_high = 1'b1;
        ld_high_val = PTR_CMD_VAL_I; // see [RULE_07]
      end
      wrg_pkg::WRG_CMD_NONE: begin
      end
    endcase
  end

  // ****************************************************************
  // The two independent slice pointers
  // ****************************************************************
  // Separate storage, so any slice pair in any order is legal
  wrg_slice_ptr #(
    .RESET_VAL(`WRG_RST_PTR_LOW)
  ) u_ptr_low (
    .clk_i(CLK_I),
    .arst_n_i(ARST_N_I),
    .ld_en_i(ld_low),
    .ld_val_i(ld_low_val),
    .ptr_o(ptr_low)
  ); // see [RULE_04] see [RULE_10] see [RULE_20]

  wrg_slice_ptr #(
    .RESET_VAL(`WRG_RST_PTR_HIGH)
  ) u_ptr_high (
    .clk_i(CLK_I),
    .arst_n_i(ARST_N_I),
    .ld_en_i(ld_high),
    .ld_val_i(ld_high_val),
    .ptr_o(ptr_high)
  ); // see [RULE_04] see [RULE_10] see [RULE_20]

  // ****************************************************************
  // Page select pointer
  // ****************************************************************
  logic [7:0] page_ptr_ff;

  // Zero after reset, so page 0 prime is reachable at once
  always_ff @(posedge CLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      page_ptr_ff <= `WRG_RST_PAGE_PTR; // see [RULE_19] see [RULE_02]
    end else if (wr_page) begin
      page_ptr_ff <= REG_WR_DATA_I; // see [RULE_02]
    end
  end

  // ****************************************************************
  // Operand resolution, one resolver per operand role
  // ****************************************************************
  logic [7:0] src_addr;
  wrg_pkg::wrg_space_type src_space;
  logic [3:0] src_page;
  logic src_wref;
  logic src_odd;
  logic [7:0] dst_addr;
  wrg_pkg::wrg_space_type dst_space;
  logic [3:0] dst_page;
  logic dst_wref;
  logic dst_odd;

  // Source role takes the low page nibble
  wrg_operand_resolve u_src (
    .mode_i(SRC_MODE_I),
    .field_i(SRC_FIELD_I),
    .pair_i(SRC_PAIR_I),
    .ptr_low_i(ptr_low),
    .ptr_high_i(ptr_high),
    .page_i(page_ptr_ff[`WRG_PAGE_SRC_MSB:`WRG_PAGE_SRC_LSB]), // see [RULE_02]
    .addr_o(src_addr),
    .space_o(src_space),
    .page_o(src_page),
    .wref_o(src_wref),
    .odd_o(src_odd)
  );

  // Destination role takes the high page nibble
  wrg_operand_resolve u_dst (
    .mode_i(DST_MODE_I),
    .field_i(DST_FIELD_I),
    .pair_i(DST_PAIR_I),
    .ptr_low_i(ptr_low),
    .ptr_high_i(ptr_high),
    .page_i(page_ptr_ff[`WRG_PAGE_DST_MSB:`WRG_PAGE_DST_LSB]), // see [RULE_02]
    .addr_o(dst_addr),
    .space_o(dst_space),
    .page_o(dst_page),
    .wref_o(dst_wref),
    .odd_o(dst_odd)
  );

  // ****************************************************************
  // Registered operand answer
  // ****************************************************************
  // Uses pointers as they stood before this edge; a pointer load and
  // an operand in the same cycle see the old pointer value
  always_ff @(posedge CLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      OPND_VALID_O <= 1'b0;
    end else begin
      OPND_VALID_O <= OPND_VALID_I;
    end
  end

  // Address fields held until the next request
  always_ff @(posedge CLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      SRC_ADDR_O <= 8'h00;
      SRC_SPACE_O <= wrg_pkg::WRG_SPACE_PRIME;
      SRC_PAGE_O <= 4'h0;
      SRC_WREF_O <= 1'b0;
      SRC_ODD_O <= 1'b0;
      DST_ADDR_O <= 8'h00;
      DST_SPACE_O <= wrg_pkg::WRG_SPACE_PRIME;
      DST_PAGE_O <= 4'h0;
      DST_WREF_O <= 1'b0;
      DST_ODD_O <= 1'b0;
    end else if (OPND_VALID_I) begin
      SRC_ADDR_O <= src_addr; // see [RULE_05]
      SRC_SPACE_O <= src_space;
      SRC_PAGE_O <= src_page;
      SRC_WREF_O <= src_wref;
      SRC_ODD_O <= src_odd; // see [RULE_12]
      DST_ADDR_O <= dst_addr; // see [RULE_05]
      DST_SPACE_O <= dst_space;
      DST_PAGE_O <= dst_page;
      DST_WREF_O <= dst_wref;
      DST_ODD_O <= dst_odd; // see [RULE_12]
    end
  end

  // ****************************************************************
  // Control register read back
  // ****************************************************************
  // Misses answer zero so the datapath may OR several sources
  always_ff @(posedge CLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      REG_RD_HIT_O <= 1'b0;
      REG_RD_DATA_O <= 8'h00;
    end else begin
      REG_RD_HIT_O <= 1'b0;
      REG_RD_DATA_O <= 8'h00;
      if (rd_set1) begin
        unique case (REG_RD_ADDR_I)
          `WRG_OFS_PTR_LOW: begin
            REG_RD_HIT_O <= 1'b1;
            REG_RD_DATA_O <= ptr_low; // see [RULE_21]
          end
          `WRG_OFS_PTR_HIGH: begin
            REG_RD_HIT_O <= 1'b1;
            REG_RD_DATA_O <= ptr_high; // see [RULE_21]
          end
          `WRG_OFS_PAGE_PTR: begin
            REG_RD_HIT_O <= 1'b1;
            REG_RD_DATA_O <= page_ptr_ff;
          end
          default: begin
          end
        endcase
      end
    end
  end

  // ****************************************************************
  // Live state mirrors
  // ****************************************************************
  // Copies so each top output comes from its own flip-flop
  always_ff @(posedge CLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      SLICE_PTR_LOW_O <= `WRG_RST_PTR_LOW;
      SLICE_PTR_HIGH_O <= `WRG_RST_PTR_HIGH;
      PAGE_PTR_O <= `WRG_RST_PAGE_PTR;
    end else begin
      SLICE_PTR_LOW_O <= ptr_low;
      SLICE_PTR_HIGH_O <= ptr_high;
      PAGE_PTR_O <= page_ptr_ff;
    end
  end

endmodule

// *** tb/wrg_addr_gen_properties.sv ***
`timescale 1ns/1ps
// ****
// Port-level checks of address formation
// ****
module wrg_addr_gen_properties (
  // Clock, reset and requests
  input wire logic CLK_I, ARST_N_I, REG_WR_EN_I, REG_WR_SET2_I, REG_RD_EN_I, REG_RD_SET2_I,
  input wire logic OPND_VALID_I, SRC_PAIR_I,
  input wire wrg_pkg::wrg_cmd_type PTR_CMD_I,
  input wire wrg_pkg::wrg_mode_type SRC_MODE_I, DST_MODE_I,
  input wire logic [7:0] PTR_CMD_VAL_I, REG_WR_ADDR_I, REG_WR_DATA_I, REG_RD_ADDR_I, SRC_FIELD_I, DST_FIELD_I,
  // Answers
  input wire logic OPND_VALID_O, SRC_WREF_O, SRC_ODD_O, REG_RD_HIT_O,
  input wire logic [7:0] SRC_ADDR_O, DST_ADDR_O, REG_RD_DATA_O, SLICE_PTR_LOW_O, SLICE_PTR_HIGH_O,
  input wire wrg_pkg::wrg_space_type SRC_SPACE_O, DST_SPACE_O
);
  default clocking @(posedge CLK_I); endclocking
  default disable iff (!ARST_N_I);

  // No load on the last edge: the live copies then show what a request uses
  logic quiet_ff;
  always_ff @(posedge CLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      quiet_ff <= 1'b1;
    end else begin
      quiet_ff <= (PTR_CMD_I == wrg_pkg::WRG_CMD_NONE) && !REG_WR_EN_I;
    end
  end

  // Operand resolution
  AST_VALID_LAG: assert property (OPND_VALID_O == $past(OPND_VALID_I))
    else $error("operand valid lag wrong");
  AST_WORK4: assert property (OPND_VALID_I && SRC_MODE_I == wrg_pkg::WRG_MODE_WORK4 && quiet_ff
    |=> SRC_WREF_O && SRC_SPACE_O != wrg_pkg::WRG_SPACE_SET2 && SRC_ADDR_O ==
    {$past(SRC_FIELD_I[3] ? SLICE_PTR_HIGH_O[7:3] : SLICE_PTR_LOW_O[7:3]), $past(SRC_FIELD_I[2:0])})
    else $error("short working address wrong");
  AST_REG8_WORK: assert property (OPND_VALID_I && DST_MODE_I == wrg_pkg::WRG_MODE_REG8
    && DST_FIELD_I[7:4] == 4'hC && quiet_ff |=> DST_ADDR_O ==
    {$past(DST_FIELD_I[3] ? SLICE_PTR_HIGH_O[7:3] : SLICE_PTR_LOW_O[7:3]), $past(DST_FIELD_I[2:0])})
    else $error("long working address wrong");
  AST_DIRECT: assert property (OPND_VALID_I && DST_MODE_I == wrg_pkg::WRG_MODE_REG8
    && DST_FIELD_I[7:4] != 4'hC |=> DST_ADDR_O == $past(DST_FIELD_I)
    && (DST_SPACE_O == wrg_pkg::WRG_SPACE_SET1) == (DST_ADDR_O > 8'hBF))
    else $error("direct address wrong");
  AST_INDIR: assert property (OPND_VALID_I && SRC_MODE_I == wrg_pkg::WRG_MODE_INDIR
    && SRC_FIELD_I > 8'hBF |=> SRC_SPACE_O == wrg_pkg::WRG_SPACE_SET2 && !SRC_WREF_O)
    else $error("indirect space wrong");
  AST_PAIR_ODD: assert property (OPND_VALID_I && SRC_PAIR_I |=> SRC_ODD_O == SRC_ADDR_O[0])
    else $error("pair odd flag wrong");

  // Pointer loads show on the live copies two edges on
  AST_SET_BOTH: assert property (PTR_CMD_I == wrg_pkg::WRG_CMD_BOTH |-> ##2
    SLICE_PTR_LOW_O == $past(PTR_CMD_VAL_I, 2) && SLICE_PTR_HIGH_O == $past(PTR_CMD_VAL_I, 2) + 8'h08)
    else $error("set both pointers wrong");
  AST_SET_LOW: assert property (PTR_CMD_I == wrg_pkg::WRG_CMD_LOW && !REG_WR_EN_I |-> ##2
    SLICE_PTR_LOW_O == $past(PTR_CMD_VAL_I, 2) && $stable(SLICE_PTR_HIGH_O))
    else $error("set low pointer wrong");
  AST_WR_HIGH: assert property (REG_WR_EN_I && !REG_WR_SET2_I && REG_WR_ADDR_I == 8'hD7
    && PTR_CMD_I == wrg_pkg::WRG_CMD_NONE |-> ##2 SLICE_PTR_HIGH_O == $past(REG_WR_DATA_I, 2)
    && $stable(SLICE_PTR_LOW_O))
    else $error("high pointer write wrong");

  // Register reads
  AST_READ_LOW: assert property (REG_RD_EN_I && !REG_RD_SET2_I && REG_RD_ADDR_I == 8'hD6
    |=> REG_RD_HIT_O && REG_RD_DATA_O == SLICE_PTR_LOW_O)
    else $error("low pointer read wrong");
  AST_READ_MISS: assert property (REG_RD_EN_I && (REG_RD_SET2_I
    || !(REG_RD_ADDR_I inside {8'hD6, 8'hD7, 8'hDF})) |=> !REG_RD_HIT_O && REG_RD_DATA_O == 8'h00)
    else $error("read miss wrong");
endmodule

bind wrg_addr_gen wrg_addr_gen_properties chk (.CLK_I, .ARST_N_I, .REG_WR_EN_I, .REG_WR_SET2_I,
  .REG_RD_EN_I, .REG_RD_SET2_I, .OPND_VALID_I, .SRC_PAIR_I, .PTR_CMD_I, .SRC_MODE_I, .DST_MODE_I,
  .PTR_CMD_VAL_I, .REG_WR_ADDR_I, .REG_WR_DATA_I, .REG_RD_ADDR_I, .SRC_FIELD_I, .DST_FIELD_I,
  .OPND_VALID_O, .SRC_WREF_O, .SRC_ODD_O, .REG_RD_HIT_O, .SRC_ADDR_O, .DST_ADDR_O, .REG_RD_DATA_O,
  .SLICE_PTR_LOW_O, .SLICE_PTR_HIGH_O, .SRC_SPACE_O, .DST_SPACE_O);

// *** tb/wrg_cpu_model.sv ***
`timescale 1ns/1ps
// ****
// Decoder side: one request per call
// ****
module wrg_cpu_model (
  // Clock
  input wire logic clk_i,
  // Requests
  output wrg_pkg::wrg_cmd_type cmd_o,
  output wrg_pkg::wrg_mode_type mode_o,
  output logic [7:0] val_o, wa_o, wd_o, ra_o, fld_o,
  output logic we_o, ws2_o, re_o, rs2_o, ov_o, pair_o
);
  // Idle from time zero
  initial begin
    cmd_o = wrg_pkg::WRG_CMD_NONE;
    mode_o = wrg_pkg::WRG_MODE_WORK4;
    {val_o, wa_o, wd_o, ra_o, fld_o, we_o, ws2_o, re_o, rs2_o, ov_o, pair_o} = '0;
  end

  // Pointer instruction, one-cycle pulse
  task automatic cmd(input wrg_pkg::wrg_cmd_type c, input logic [7:0] v);
    @(posedge clk_i);
    cmd_o <= c;
    val_o <= v;
    @(posedge clk_i);
    cmd_o <= wrg_pkg::WRG_CMD_NONE;
  endtask

  // Register write, one-cycle strobe
  task automatic wr(input logic [7:0] a, d, input logic s2);
    @(posedge clk_i);
    we_o <= 1'b1;
    wa_o <= a;
    wd_o <= d;
    ws2_o <= s2;
    @(posedge clk_i);
    we_o <= 1'b0;
  endtask

  // Register read; answer settles just after the taking edge
  task automatic rd(input logic [7:0] a, input logic s2);
    @(posedge clk_i);
    re_o <= 1'b1;
    ra_o <= a;
    rs2_o <= s2;
    @(posedge clk_i);
    re_o <= 1'b0;
    #1;
  endtask

  // Operand request, one-cycle valid; answer settles just after the taking edge
  task automatic opnd(input wrg_pkg::wrg_mode_type m, input logic [7:0] f, input logic p);
    @(posedge clk_i);
    ov_o <= 1'b1;
    mode_o <= m;
    fld_o <= f;
    pair_o <= p;
    @(posedge clk_i);
    ov_o <= 1'b0;
    #1;
  endtask
endmodule

// *** tb/tb.sv ***
`timescale 1ns/1ps
// ****
// Bench for the address generator
// ****
module tb;
  logic clk = 1'b0;
  logic arst_n = 1'b0;
  int err_total = 0;
  int compares = 0;
  int cyc = 0;
  wrg_pkg::wrg_cmd_type cmd;
  wrg_pkg::wrg_mode_type md;
  wrg_pkg::wrg_space_type ss, ds;
  logic [7:0] val, wa, wd, ra, fld, sa, da, rdd, pl, ph, pp;
  logic we, ws2, re, rs2, ov, pr, ovo, swr, sod, dwr, dod, hit;
  logic [3:0] spg, dpg;

  // 25 MHz clock
  always #20 clk = ~clk;

  wrg_cpu_model cpu (.clk_i(clk), .cmd_o(cmd), .mode_o(md), .val_o(val), .wa_o(wa), .wd_o(wd),
    .ra_o(ra), .fld_o(fld), .we_o(we), .ws2_o(ws2), .re_o(re), .rs2_o(rs2), .ov_o(ov), .pair_o(pr));

  // Source and destination share one request so both paths are exercised
  wrg_addr_gen uut (.CLK_I(clk), .ARST_N_I(arst_n), .PTR_CMD_I(cmd), .PTR_CMD_VAL_I(val),
    .REG_WR_EN_I(we), .REG_WR_ADDR_I(wa), .REG_WR_SET2_I(ws2), .REG_WR_DATA_I(wd),
    .REG_RD_EN_I(re), .REG_RD_ADDR_I(ra), .REG_RD_SET2_I(rs2), .OPND_VALID_I(ov),
    .SRC_MODE_I(md), .SRC_FIELD_I(fld), .SRC_PAIR_I(pr), .DST_MODE_I(md), .DST_FIELD_I(fld),
    .DST_PAIR_I(pr), .OPND_VALID_O(ovo), .SRC_ADDR_O(sa), .SRC_SPACE_O(ss), .SRC_PAGE_O(spg),
    .SRC_WREF_O(swr), .SRC_ODD_O(sod), .DST_ADDR_O(da), .DST_SPACE_O(ds), .DST_PAGE_O(dpg),
    .DST_WREF_O(dwr), .DST_ODD_O(dod), .REG_RD_HIT_O(hit), .REG_RD_DATA_O(rdd),
    .SLICE_PTR_LOW_O(pl), .SLICE_PTR_HIGH_O(ph), .PAGE_PTR_O(pp));

  // One comparison
  task automatic chk(input string n, input logic [7:0] e, g);
    compares++;
    if (g !== e) begin
      err_total++;
      $display("mismatch %s exp %h got %h", n, e, g);
    end
  endtask

  // Read and compare hit and data
  task automatic rchk(input logic [7:0] a, input logic s2, h, input logic [7:0] e);
    cpu.rd(a, s2);
    chk("read hit", {7'h00, h}, {7'h00, hit});
    chk("read data", e, rdd);
  endtask

  // Operand on both paths; space code 0 prime, 1 set 1, 2 set 2; w is the working flag
  task automatic ochk(input wrg_pkg::wrg_mode_type m, input logic [7:0] f, e, input logic [1:0] s,
                      input logic w, p);
    cpu.opnd(m, f, p);
    chk("valid", 8'h01, {7'h00, ovo});
    chk("src addr", e, sa);
    chk("dst addr", e, da);
    chk("space", {4'h0, s, s}, {4'h0, ss, ds});
    chk("wref", {6'h00, w, w}, {6'h00, swr, dwr});
    chk("odd", {6'h00, p & e[0], p & e[0]}, {6'h00, sod, dod});
  endtask

  // Verdict and end of run
  task automatic give_verdict;
    $display("compares %0d err_total %0d", compares, err_total);
    if (err_total == 0 && compares > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  // Hang guard, far above the hundred or so cycles needed
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      err_total++;
      give_verdict;
    end
  end

  // Main sequence
  initial begin
    repeat (16) @(posedge clk);
    arst_n <= 1'b1;
    rchk(8'hD6, 1'b0, 1'b1, 8'hC0);
    rchk(8'hD7, 1'b0, 1'b1, 8'hC8);
    rchk(8'hDF, 1'b0, 1'b1, 8'h00);
    rchk(8'hD8, 1'b0, 1'b0, 8'h00);
    rchk(8'hD6, 1'b1, 1'b0, 8'h00);
    ochk(wrg_pkg::WRG_MODE_WORK4, 8'h02, 8'hC2, 2'h1, 1'b1, 1'b0);
    ochk(wrg_pkg::WRG_MODE_WORK4, 8'h0B, 8'hCB, 2'h1, 1'b1, 1'b0);
    cpu.cmd(wrg_pkg::WRG_CMD_BOTH, 8'h70);
    ochk(wrg_pkg::WRG_MODE_WORK4, 8'h06, 8'h76, 2'h0, 1'b1, 1'b0);
    chk("pages", 8'h00, {dpg, spg});
    ochk(wrg_pkg::WRG_MODE_WORK4, 8'h0E, 8'h7E, 2'h0, 1'b1, 1'b0);
    cpu.cmd(wrg_pkg::WRG_CMD_HIGH, 8'h48);
    cpu.cmd(wrg_pkg::WRG_CMD_LOW, 8'hA0);
    rchk(8'hD6, 1'b0, 1'b1, 8'hA0);
    rchk(8'hD7, 1'b0, 1'b1, 8'h48);
    // Clear low, load high, then a set 2 write that must not land
    cpu.wr(8'hD6, 8'h00, 1'b0);
    cpu.wr(8'hD7, 8'hF8, 1'b0);
    cpu.wr(8'hD7, 8'h11, 1'b1);
    rchk(8'hD6, 1'b0, 1'b1, 8'h00);
    rchk(8'hD7, 1'b0, 1'b1, 8'hF8);
    ochk(wrg_pkg::WRG_MODE_WORK4, 8'h09, 8'hF9, 2'h1, 1'b1, 1'b0);
    ochk(wrg_pkg::WRG_MODE_WORK4, 8'h03, 8'h03, 2'h0, 1'b1, 1'b0);
    cpu.cmd(wrg_pkg::WRG_CMD_HIGH, 8'hAD);
    rchk(8'hD7, 1'b0, 1'b1, 8'hAD);
    ochk(wrg_pkg::WRG_MODE_REG8, 8'hCB, 8'hAB, 2'h0, 1'b1, 1'b0);
    ochk(wrg_pkg::WRG_MODE_REG8, 8'hC4, 8'h04, 2'h0, 1'b1, 1'b0);
    ochk(wrg_pkg::WRG_MODE_REG8, 8'h81, 8'h81, 2'h0, 1'b0, 1'b1);
    ochk(wrg_pkg::WRG_MODE_REG8, 8'h80, 8'h80, 2'h0, 1'b0, 1'b1);
    ochk(wrg_pkg::WRG_MODE_REG8, 8'hD6, 8'hD6, 2'h1, 1'b0, 1'b0);
    ochk(wrg_pkg::WRG_MODE_INDIR, 8'hE0, 8'hE0, 2'h2, 1'b0, 1'b0);
    ochk(wrg_pkg::WRG_MODE_INDIR, 8'h10, 8'h10, 2'h0, 1'b0, 1'b0);
    // High pointer wraps past FFH
    cpu.cmd(wrg_pkg::WRG_CMD_BOTH, 8'hF8);
    rchk(8'hD7, 1'b0, 1'b1, 8'h00);
    ochk(wrg_pkg::WRG_MODE_WORK4, 8'h0F, 8'h07, 2'h0, 1'b1, 1'b0);
    ochk(wrg_pkg::WRG_MODE_WORK4, 8'h07, 8'hFF, 2'h1, 1'b1, 1'b0);
    cpu.wr(8'hDF, 8'h21, 1'b0);
    ochk(wrg_pkg::WRG_MODE_REG8, 8'h10, 8'h10, 2'h0, 1'b0, 1'b0);
    chk("pages", 8'h21, {dpg, spg});
    chk("live low", 8'hF8, pl);
    chk("live high", 8'h00, ph);
    chk("live page", 8'h21, pp);
    // Mid-run reset, pointers back on the common area
    @(posedge clk);
    arst_n <= 1'b0;
    @(posedge clk);
    #1;
    chk("reset low", 8'hC0, pl);
    chk("reset high", 8'hC8, ph);
    chk("reset page", 8'h00, pp);
    @(posedge clk);
    arst_n <= 1'b1;
    rchk(8'hD6, 1'b0, 1'b1, 8'hC0);
    rchk(8'hD7, 1'b0, 1'b1, 8'hC8);
    give_verdict;
  end
endmodule
